// File: core/pso_pkg.sv
// constants for the eight-stage parallel-in serial-out shift register
package pso_pkg;
	localparam int STAGES = 8;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;
	localparam logic [7:0] STAGE_RESET = 8'h00;
	localparam logic [3:0] FIFO_COUNT_RESET = 4'h0;
	localparam logic [2:0] FIFO_PTR_RESET = 3'h0;
	typedef logic [7:0] pso_word_t;
endpackage : pso_pkg

// File: core/pso_fifo.sv
// parameterised valid/ready fifo holding parallel words before they load the stages
`timescale 1ns/100ps
`default_nettype none
module pso_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop)
			begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			count <= '0;
		end
		else if (push && !pop)
		begin
			count <= count + 1'b1;
		end
		else if (pop && !push)
		begin
			count <= count - 1'b1;
		end
	end
endmodule : pso_fifo
`default_nettype wire

// File: core/pso_shift_reg.sv
// eight-stage parallel-in serial-out shift register, sampled on the system clock
// Function
// R1: load-control low copies the eight parallel inputs into every stage, ignoring clocks; code loads one queued fifo word per low window, if any.
// R2: load-control high shifts serial_data_in into stage one on a rising clock.
// R3: both clock inputs behave identically; either can be the shift clock.
// R4: one clock input held high blocks activity on the other (inhibit).
// R5: the driver should raise the inhibit only while the clock is high.
// R6: stages hold forever without clocking; any slow or stopped clock works.
// R7: last stage drives a true output and a complemented output.
// R8: each rising edge of the OR of both clocks shifts stages toward the eighth.
`timescale 1ns/100ps
`default_nettype none
module pso_shift_reg
	import pso_pkg::*;
(
	input  wire logic                         clk,
	input  wire logic                         rstn,
	input  wire logic                         shift_n_load,
	input  wire logic [pso_pkg::STAGES-1:0]   par_data,
	input  wire logic                         par_valid,
	output logic                              par_ready,
	input  wire logic                         serial_data_in,
	input  wire logic                         shift_clk_a,
	input  wire logic                         shift_clk_b,
	output logic                              last_stage_out,
	output logic                              last_stage_out_n
);
	import pso_pkg::*;

	typedef enum logic [0:0] {PSO_IDLE, PSO_HELD} pso_load_e;

	pso_word_t        stage;
	pso_word_t        fifo_data;
	logic             fifo_valid;
	logic             fifo_push;
	logic             fifo_pop;
	logic [3:0]       fill;
	logic [3:0]       next_fill;
	logic             clk_or;
	logic             clk_or_d;
	logic             shift_edge;
	pso_load_e        load_state;
	pso_load_e        next_load_state;

	// shift position: stage[0] is first, stage[7] the eighth
	function automatic pso_word_t pso_shift(input pso_word_t cur, input logic din);
		pso_shift = {cur[STAGES-2:0], din};
	endfunction : pso_shift

	// parallel words queue here so the source sees back-pressure while loads drain
	pso_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_data   (par_data),
		.in_valid  (fifo_push),
		.in_ready  (),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	// one word per load-low window; a held load keeps that word in the stages and pops no other
	always_comb
	begin
		next_load_state = load_state;
		case (load_state)
			PSO_IDLE:
			begin
				if (!shift_n_load && fifo_valid)
				begin
					next_load_state = PSO_HELD;
				end
			end
			PSO_HELD:
			begin
				if (shift_n_load)
				begin
					next_load_state = PSO_IDLE;
				end
			end
			default:
			begin
				next_load_state = PSO_IDLE;
			end
		endcase
	end

	assign fifo_pop = (load_state == PSO_IDLE) && !shift_n_load && fifo_valid;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			load_state <= PSO_IDLE;
		end
		else
		begin
			load_state <= next_load_state;
		end
	end

	// ready is a flop, so it must already reflect the fill after this edge
	assign fifo_push = par_valid && par_ready;

	always_comb
	begin
		next_fill = fill;
		if (fifo_push && !fifo_pop)
		begin
			next_fill = fill + 4'h1;
		end
		else if (fifo_pop && !fifo_push)
		begin
			next_fill = fill - 4'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			fill      <= FIFO_COUNT_RESET;
			par_ready <= 1'b0;
		end
		else
		begin
			fill      <= next_fill;
			par_ready <= (next_fill != 4'(FIFO_DEPTH));
		end
	end

	// either pin high holds the OR high, so the other pin cannot make an edge
	assign clk_or = shift_clk_a | shift_clk_b; // R3 R4 R8
	assign shift_edge = clk_or && !clk_or_d; // R8

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			clk_or_d <= 1'b1;
		end
		else
		begin
			clk_or_d <= clk_or;
		end
	end

	// load wins over any clock edge; no edge means stages keep their value
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			stage <= STAGE_RESET;
		end
		else if (fifo_pop)
		begin
			stage <= fifo_data; // R1
		end
		else if (!shift_n_load)
		begin
			stage <= stage; // R1 R6
		end
		else if (shift_edge)
		begin
			stage <= pso_shift(stage, serial_data_in); // R2 R8
		end
	end

	// outputs follow the eighth stage one cycle later, straight from flops
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			last_stage_out   <= STAGE_RESET[STAGES-1];
			last_stage_out_n <= ~STAGE_RESET[STAGES-1];
		end
		else
		begin
			last_stage_out   <= stage[STAGES-1]; // R7
			last_stage_out_n <= ~stage[STAGES-1]; // R7
		end
	end
endmodule : pso_shift_reg
`default_nettype wire

// File: tb/pso_shift_reg_asserts.sv
// port-level checks of the shift register
`timescale 1ns/100ps
`default_nettype none
module pso_shift_reg_asserts (
	input wire logic clk,
	input wire logic rstn,
	input wire logic shift_n_load,
	input wire logic serial_data_in,
	input wire logic shift_clk_a,
	input wire logic shift_clk_b,
	input wire logic last_stage_out,
	input wire logic last_stage_out_n
);
	logic       or_q;
	logic [7:0] sh;
	logic [3:0] n;
	wire logic  ld = !shift_n_load;
	wire logic  up = (shift_clk_a | shift_clk_b) & ~or_q & shift_n_load;
	wire logic  ev = up | ld;
	wire logic  fl = up & (n > 4'h6);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// shadow is only trusted after eight shifts since the last load window
	always_ff @(posedge clk)
	begin
		or_q <= !rstn | shift_clk_a | shift_clk_b;
		sh   <= up ? {sh[6:0], serial_data_in} : sh;
		n    <= (!rstn | ld) ? 4'h0 : n + {3'h0, up & (n < 4'h8)};
	end
	a_out_compl: assert property (last_stage_out_n != last_stage_out)
		else $error("bad complement");
	a_shift_a: assert property (fl & shift_clk_a |-> ##2 last_stage_out == $past(sh[7]))
		else $error("bad shift on a");
	a_shift_b: assert property (fl & !shift_clk_a |-> ##2 last_stage_out == $past(sh[7]))
		else $error("bad shift on b");
	a_hold_idle: assert property (shift_n_load & !up |-> ##2 $stable(last_stage_out))
		else $error("moved without edge");
	a_inhibit_hold: assert property (shift_n_load & shift_clk_b & $past(shift_clk_b)
		& $rose(shift_clk_a) |-> ##2 $stable(last_stage_out))
		else $error("inhibit ignored");
	a_load_once: assert property (ld ##1 ld |-> ##2 $stable(last_stage_out))
		else $error("load window moved twice");
	a_edge_cause: assert property ($changed(last_stage_out) |-> $past(ev, 2))
		else $error("change without cause");
	cover property (fl);
	cover property (ld ##1 ld);
	cover property (shift_clk_b & $rose(shift_clk_a));
endmodule : pso_shift_reg_asserts
bind pso_shift_reg pso_shift_reg_asserts pso_shift_reg_asserts_inst (.clk, .rstn,
	.shift_n_load, .serial_data_in, .shift_clk_a, .shift_clk_b, .last_stage_out,
	.last_stage_out_n);
`default_nettype wire

// File: tb/pso_ctl_model.sv
// controller model driving the load and clock pins
`timescale 1ns/100ps
`default_nettype none
module pso_ctl_model (
	input  wire logic       clk,
	input  wire logic [1:0] cmd,
	input  wire logic       inh,
	output var logic        snl = 1'b1,
	output var logic        ca = 1'b0,
	output var logic        cb = 1'b0
);
	always @(negedge clk)
	begin
		snl <= cmd != 2'h1;
		ca  <= cmd == 2'h2;
		cb  <= (cmd == 2'h3) | (inh & (ca | cb));
	end
endmodule : pso_ctl_model
`default_nettype wire

// File: tb/tb_pso_shift_reg.sv
// testbench for the shift register with its word fifo
`timescale 1ns/100ps
`default_nettype none
module tb_pso_shift_reg;
	import pso_pkg::*;
	logic       clk = 0, rstn = 0, pv = 0, sdi = 0, inh = 0;
	logic [1:0] cmd = 2'h0;
	pso_word_t  pd = 8'h00, ex;
	wire logic  snl, ca, cb, pr, q, qn;
	int         num_errors = 0, checks_done = 0, cyc = 0;
	logic [9:0] rows [8] = '{10'h003, 10'h3fc, 10'h297, 10'h168, 10'h203, 10'h004, 10'h0f3,
		10'h30c};
	always #50 clk = ~clk;
	pso_ctl_model pso_ctl_model_inst (.clk, .cmd, .inh, .snl, .ca, .cb);
	pso_shift_reg pso_shift_reg_inst (.clk, .rstn, .shift_n_load(snl), .par_data(pd),
		.par_valid(pv), .par_ready(pr), .serial_data_in(sdi), .shift_clk_a(ca),
		.shift_clk_b(cb), .last_stage_out(q), .last_stage_out_n(qn));
	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	task chk(input string nm, input logic e, input logic s);
		checks_done++;
		if (s !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %b seen %b", nm, e, s);
		end
	endtask : chk
	task rst_chk;
		chk("reset_q", 1'b0, q);
		chk("reset_qn", 1'b1, qn);
		chk("reset_ready", 1'b0, pr);
	endtask : rst_chk
	// output settles two edges after the model moves the pin
	task op(input logic [1:0] c, input int len);
		cmd <= c;
		repeat (len) @(negedge clk);
		cmd <= 2'h0;
		repeat (2) @(negedge clk);
	endtask : op
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 1000)
		begin
			num_errors++;
			finish_test();
		end
	end
	initial
	begin
		repeat (8) @(negedge clk);
		rst_chk();
		rstn = 1;
		repeat (3) @(negedge clk);
		pv = 1;
		for (int i = 0; i < 9; i++)
		begin
			pd = i < 8 ? rows[i][9:2] : 8'hff;
			@(negedge clk);
		end
		pv = 0;
		chk("ready", 1'b0, pr);
		$display("fill done");
		foreach (rows[i])
		begin
			ex = rows[i][9:2];
			sdi = rows[i][1];
			op(2'h1, 1);
			chk("load", ex[7], q);
			for (int k = 0; k < 8; k++)
			begin
				op(2'h2 + 2'(i % 2), 1);
				ex = {ex[6:0], sdi};
				chk("shift", ex[7], q);
				chk("shift_n", ~ex[7], qn);
			end
			chk("final", rows[i][0], q);
		end
		$display("rows done");
		// ones everywhere, so a stale word loaded from an empty fifo would show
		sdi = 1;
		repeat (8) op(2'h3, 1);
		ex = 8'hff;
		op(2'h1, 2);
		repeat (20) @(negedge clk);
		chk("hold", ex[7], q);
		chk("ready", 1'b1, pr);
		sdi = 0;
		inh <= 1;
		repeat (8) op(2'h2, 1);
		ex = {ex[6:0], 1'b0};
		inh <= 0;
		@(negedge clk);
		chk("inhibit", ex[7], q);
		sdi = 1;
		repeat (7) op(2'h2, 1);
		ex = {ex[0], 7'h7f};
		chk("after", ex[7], q);
		op(2'h2, 1);
		ex = {ex[6:0], 1'b1};
		chk("after", ex[7], q);
		$display("inhibit done");
		rstn = 0;
		repeat (2) @(negedge clk);
		rst_chk();
		rstn = 1;
		@(negedge clk);
		chk("ready", 1'b1, pr);
		$display("reset done");
		finish_test();
	end
endmodule : tb_pso_shift_reg
`default_nettype wire
